// [aux_dac_sweep_generator_tb.sv]
// Purpose: Self-checking bench for the auxiliary DAC sweep generator
// Assumes: Slave answers within 20 clocks; default sample period shortened to 20 clocks
// Notes: Triggered sample rate keeps most steps under bench control; one test uses the internal rate
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module aux_dac_sweep_generator_tb import axs_pkg::*;;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] avs_address_i = '0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = '0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic trig_i = 1'b0;
   logic [NCH-1:0][15:0] dac_o;
   logic [NCH-1:0] dac_upd_o;
   logic scan_run_o;
   logic [NCH-1:0][15:0] volt;
   logic [31:0] q;
   logic [15:0] v;
   int error_cnt = 0;
   int cmp_count = 0;
   // Clock at 100 ns period
   always #50 clock_i = ~clock_i;
   axs_sweep #(.RATE_RST_P(32'h14)) axs_sweep_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .trig_i(trig_i), .dac_o(dac_o),
      .dac_upd_o(dac_upd_o), .scan_run_o(scan_run_o));
   axs_dac_model axs_dac_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .dac_i(dac_o),
      .upd_i(dac_upd_o), .volt_o(volt));
   // Verdict and end of run
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One bus access, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= rd;
      avs_write_i <= !rd;
      do begin
         @(posedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (avs_waitrequest_o !== 1'b0) begin
         error_cnt++;
         conclude();
      end
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   // Trigger pulse long enough for the synchroniser
   task automatic trg;
      trig_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      trig_i <= 1'b0;
      repeat (4) @(posedge clock_i);
   endtask
   // Let the engine finish a round, then compare channel 0
   task automatic dac0(input logic [15:0] e);
      repeat (200) @(posedge clock_i);
      `CHK(volt[0], e)
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      bus(1, ADDR_START, 0); `CHK(q, 32'h000003e8)
      bus(1, ADDR_STOP, 0); `CHK(q, 32'h00001388)
      bus(1, 8'h3c, 0); `CHK(q, 32'h00000000)
      for (int i = 1; i <= 4; i++) begin
         bus(0, ADDR_CTRL, 32'h00000100);
         bus(1, ADDR_SEL, 0); `CHK(q, 32'(i % 4))
      end
      $display("test registers and selector done");
      bus(0, ADDR_LEVEL, 32'h00002710);
      bus(0, ADDR_LEVEL, 32'h00002711);
      dac0(16'h2710);
      bus(1, ADDR_OUT, 0); `CHK(q, 32'h00002710)
      bus(0, ADDR_START, 32'h00005209);
      bus(1, ADDR_START, 0); `CHK(q, 32'h000003e8)
      $display("test fixed level done");
      bus(0, ADDR_MODE, 32'h00000001);
      bus(0, ADDR_OFFS, 32'h0000f060);
      bus(0, ADDR_NPTS, 32'h00000004);
      bus(0, ADDR_CTRL, 32'h00000046);
      dac0(16'hf448);
      trg();
      bus(1, ADDR_STAT, 0); `CHK(q[1:0], 2'h1)
      `CHK(scan_run_o, 1'b1)
      dac0(16'hf448);
      bus(0, ADDR_MODE, 32'h00000002);
      bus(1, ADDR_MODE, 0); `CHK(q, 32'h00000001)
      trg();
      dac0(16'hf830);
      bus(0, ADDR_CTRL, 32'h00000026);
      trg();
      dac0(16'hf830);
      bus(1, ADDR_STEP, 0); `CHK(q, 32'h00000001)
      bus(0, ADDR_CTRL, 32'h00000016);
      trg();
      dac0(16'hfc18);
      trg();
      trg();
      dac0(16'h03e8);
      bus(1, ADDR_STAT, 0); `CHK(q[1:0], 2'h3)
      bus(1, ADDR_STEP, 0); `CHK(q, 32'h00000004)
      trg();
      dac0(16'h03e8);
      $display("test single sweep done");
      bus(0, ADDR_CTRL, 32'h00000047);
      dac0(16'hf448);
      bus(1, ADDR_STEP, 0); `CHK(q, 32'h00000000)
      for (int i = 0; i < 5; i++) trg();
      bus(1, ADDR_STEP, 0); `CHK(q, 32'h00000000)
      bus(1, ADDR_STAT, 0); `CHK(q[1:0], 2'h1)
      dac0(16'hf448);
      $display("test loop sweep done");
      bus(0, ADDR_CTRL, 32'h00000041);
      trg();
      bus(1, ADDR_STAT, 0); `CHK(q[1:0], 2'h0)
      bus(0, ADDR_RATE, 32'h00001000);
      bus(0, ADDR_CTRL, 32'h00000013);
      trg();
      bus(1, ADDR_STEP, 0); `CHK(q, 32'h00000000)
      repeat (4100) @(posedge clock_i);
      bus(1, ADDR_STEP, 0); `CHK(q, 32'h00000001)
      $display("test internal rate done");
      bus(0, ADDR_CTRL, 32'h00000046);
      bus(0, ADDR_OFFS, 32'h00002905);
      bus(1, ADDR_OFFS, 0); `CHK(q, 32'h0000f060)
      bus(0, ADDR_STOP, 32'h00003a98);
      bus(1, ADDR_OFFS, 0); `CHK(q, 32'h0000ee6c)
      bus(0, ADDR_STOP, 32'h00001388);
      bus(0, ADDR_OFFS, 32'h0000f060);
      bus(0, ADDR_MODE, 32'h00000002);
      dac0(16'hf448);
      trg();
      trg();
      repeat (200) @(posedge clock_i);
      v = volt[0];
      for (int i = 0; i < 3; i++) trg();
      dac0(16'h03e8);
      bus(0, ADDR_CTRL, 32'h00000046);
      bus(0, ADDR_START, 32'h00001388);
      bus(0, ADDR_STOP, 32'h000003e8);
      dac0(16'h03e8);
      for (int i = 0; i < 4; i++) trg();
      dac0(v);
      $display("test log sweep done");
      conclude();
   end
endmodule // aux_dac_sweep_generator_tb

// [axs_dac_model.sv]
// Purpose: Behavioural model of the four auxiliary DAC channels
// Assumes: A channel loads its setpoint on its one-cycle update strobe
// Notes: Held voltages are what the bench compares against
`timescale 1ns/1ps
module axs_dac_model import axs_pkg::*; (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Setpoints from the block
   input wire logic [NCH-1:0][15:0] dac_i,
   input wire logic [NCH-1:0] upd_i,
   // Held output levels in millivolts
   output logic [NCH-1:0][15:0] volt_o
);
   // Each converter latches only its own setpoint on its own strobe
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         volt_o <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (upd_i[c]) begin
               volt_o[c] <= dac_i[c];
            end
         end
      end
   end
endmodule // axs_dac_model

// [axs_divider.sv]
// Purpose: Iterative restoring divider for sweep interpolation
// Assumes: Divisor is nonzero and stable only at start
// Notes: One quotient bit per clock; done pulses once
`timescale 1ns/1ps
module axs_divider import axs_pkg::*; (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Request
   input wire logic start_i,
   input wire logic [DIVW-1:0] dividend_i,
   input wire logic [15:0] divisor_i,
   // Answer
   output logic done_o,
   output logic [DIVW-1:0] quot_o
);
   logic [DIVW-1:0] quot_ff;
   logic [15:0] rem_ff;
   logic [15:0] dvs_ff;
   logic [5:0] cnt_ff;
   logic done_ff;
   logic [16:0] shl;
   logic ge;
   assign shl = {rem_ff, quot_ff[DIVW-1]};
   assign ge = shl >= {1'b0, dvs_ff};
   // Shift-subtract loop
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quot_ff <= '0;
         rem_ff <= '0;
         dvs_ff <= 16'h0001;
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start_i) begin
            quot_ff <= dividend_i;
            rem_ff <= '0;
            dvs_ff <= divisor_i;
            cnt_ff <= 6'(DIVW);
         end else if (cnt_ff != 6'h00) begin
            rem_ff <= ge ? 16'(shl - {1'b0, dvs_ff}) : shl[15:0];
            quot_ff <= {quot_ff[DIVW-2:0], ge};
            cnt_ff <= cnt_ff - 6'h01;
            done_ff <= cnt_ff == 6'h01;
         end
      end
   end
   assign done_o = done_ff;
   assign quot_o = quot_ff;
endmodule // axs_divider

// [axs_log2.sv]
// Purpose: Piecewise-linear base-2 logarithm and its inverse
// Assumes: Inputs are positive millivolt values below 32768
// Notes: Log of an exact value converts back exactly
`timescale 1ns/1ps
module axs_log2 import axs_pkg::*; (
   // Two logarithm lanes
   input wire logic [14:0] log_a_i,
   input wire logic [14:0] log_b_i,
   output logic [LW-1:0] log_a_o,
   output logic [LW-1:0] log_b_o,
   // Exponent lane
   input wire logic [LW-1:0] exp_i,
   output logic [14:0] exp_o
);
   function automatic logic [LW-1:0] lg(input logic [14:0] x);
      logic [3:0] e;
      logic [14:0] m;
      e = 4'h0;
      for (int b = 0; b < 15; b++) begin
         if (x[b]) e = 4'(b);
      end
      m = x << (4'he - e);
      return {e, m[13:0]};
   endfunction
   logic [28:0] p;
   // Mantissa shift for the inverse
   assign p = {14'h0000, 1'b1, exp_i[13:0]} << exp_i[LW-1:14];
   assign exp_o = p[28:14];
   assign log_a_o = lg(log_a_i);
   assign log_b_o = lg(log_b_i);
endmodule // axs_log2

// [axs_pkg.sv]
// Purpose: Shared constants and types for the auxiliary DAC sweep generator
// Assumes: Voltages are signed millivolts; registers are 32-bit Avalon-MM words
// Notes: Log math uses a 4.14 fixed-point base-2 logarithm
package axs_pkg;
   localparam int NCH = 4;
   // Clock and default sample rate
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
   localparam int SAMPLE_HZ_RST = 4;
   localparam logic [31:0] RATE_RST = 32'(CLK_HZ / SAMPLE_HZ_RST);
   localparam logic [15:0] NPTS_RST = 16'h0190;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_SEL = 8'h08;
   localparam logic [7:0] ADDR_NPTS = 8'h0c;
   localparam logic [7:0] ADDR_RATE = 8'h10;
   localparam logic [7:0] ADDR_STEP = 8'h14;
   localparam logic [7:0] ADDR_MODE = 8'h20;
   localparam logic [7:0] ADDR_LEVEL = 8'h24;
   localparam logic [7:0] ADDR_START = 8'h28;
   localparam logic [7:0] ADDR_STOP = 8'h2c;
   localparam logic [7:0] ADDR_OFFS = 8'h30;
   localparam logic [7:0] ADDR_OUT = 8'h34;
   // Control field positions
   localparam int CTRL_LOOP_BIT = 0;
   localparam int CTRL_TRIG_BIT = 1;
   localparam int CTRL_TRATE_BIT = 2;
   localparam int CMD_START_BIT = 4;
   localparam int CMD_PAUSE_BIT = 5;
   localparam int CMD_RESET_BIT = 6;
   localparam int CMD_SEL_BIT = 8;
   localparam int STAT_SEL_LSB = 4;
   // Voltage bounds in millivolts
   localparam logic signed [15:0] FIX_MIN = -16'sh2710;
   localparam logic signed [15:0] FIX_MAX = 16'sh2710;
   localparam logic signed [15:0] LIM_MIN = 16'sh0001;
   localparam logic signed [15:0] LIM_MAX = 16'sh5208;
   localparam logic signed [15:0] OUT_MAX = 16'sh2904;
   localparam logic signed [15:0] OUT_MIN = -16'sh2904;
   // Arithmetic widths
   localparam int LW = 18;
   localparam int DIVW = 34;
   typedef enum logic [1:0] {
      MODE_FIXED = 2'b00,
      MODE_LIN = 2'b01,
      MODE_LOG = 2'b10
   } axs_mode_t;
   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b00,
      SCAN_RUN = 2'b01,
      SCAN_PAUSE = 2'b10,
      SCAN_DONE = 2'b11
   } axs_scan_t;
   typedef struct packed {
      axs_mode_t mode;
      logic signed [15:0] level;
      logic signed [15:0] start;
      logic signed [15:0] stop;
      logic signed [15:0] offset;
   } axs_chan_t;
   localparam axs_chan_t CHAN_RST = '{MODE_FIXED, 16'sh0000, 16'sh03e8, 16'sh1388, 16'sh0000};
endpackage

// [axs_sweep.sv]
// Purpose: Four auxiliary DAC channels, fixed or swept, under scan control
// Assumes: Avalon-MM slave with one wait cycle; trig_i is an asynchronous pin
// Notes: A round-robin engine recomputes every swept channel from the step index; fixed channels take their level
// Function
// - Four outputs, each with own mode, level, limits and offset.
// - Swept outputs update once per sample event during the scan.
// - Scan mode chooses single sweep or continuous looping.
// - Start or continue begins advancing; pause or reset halts.
// - Paused acquisition freezes every swept output at its value.
// - Scan reset returns swept outputs to start plus offset.
// - After single sweep, outputs hold stop plus offset.
// - Programming selector steps one to four, then wraps.
// - Changing a mode to a sweep during a scan is refused.
// - Fixed mode drives level, minus to plus ten volts, millivolt steps.
// - Sweep computed from limits alone, signed offset added after.
// - Limits accepted only between one millivolt and twenty-one volts.
// - Offsets accepted only within plus or minus ten and a half volts.
// - Outputs kept within 10.5 V; limit or offset changes compensate.
// - Sweep point count equals recorded scan points.
// - Linear sweep uses N equal increments, quantised to millivolts.
// - Log sweep uses constant ratio so start times k^N equals stop.
// - Descending log sweep is the exact reverse of ascending.
// - With trigger start, a trigger edge starts scan and sweeps.
// - Internal rate with trigger start ignores later trigger edges.
// - Triggered rate: first edge starts, each later edge steps.
`timescale 1ns/1ps
module axs_sweep import axs_pkg::*; #(
   parameter logic [31:0] RATE_RST_P = RATE_RST
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Trigger pin
   input wire logic trig_i,
   // DAC setpoints
   output logic [NCH-1:0][15:0] dac_o,
   output logic [NCH-1:0] dac_upd_o,
   output logic scan_run_o
);
   typedef enum logic [1:0] {
      E_SETUP = 2'b00,
      E_WAIT = 2'b01,
      E_STORE = 2'b10
   } axs_eng_t;

   logic ack_ff, wr_en, cmd_wr, cmd_start, cmd_pause, cmd_reset;
   logic [31:0] rdata_ff, rd_mux, rate_ff, rate_cnt_ff;
   logic [2:0] ctrl_ff;
   logic [1:0] sel_ff;
   logic [15:0] npts_ff, nxt_idx, idx_ff, jdx;
   logic trig_s1_ff, trig_s2_ff, trig_d_ff, edge_seen, tick, samp, last;
   axs_scan_t scan_ff;
   axs_chan_t chan_ff [NCH];
   axs_chan_t cur, nxt_cfg, cfg;
   logic signed [15:0] wv, top, lo, hi, val, clip;
   axs_eng_t eng_ff;
   logic [1:0] ch_ff;
   logic [NCH-1:0][15:0] dac_ff;
   logic [NCH-1:0] upd_ff;
   logic asc, div_done, div_start;
   logic [LW-1:0] lg_lo, lg_hi, dlt;
   logic [DIVW-1:0] dvd, quot;
   logic [14:0] exp_v;
   logic signed [16:0] sum;

   // Bus handshake: one wait cycle, then the answer
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
   assign wr_en = avs_write_i & ack_ff;
   assign avs_readdata_o = rdata_ff;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
      end
   end

   // Read data is captured in the wait cycle
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= '0;
      end else if (avs_read_i & ~ack_ff) begin
         rdata_ff <= rd_mux;
      end
   end

   // Read map; unmapped addresses return zero
   always_comb begin
      rd_mux = '0;
      case (avs_address_i)
         ADDR_CTRL: rd_mux = {29'h0, ctrl_ff};
         ADDR_STAT: rd_mux = {26'h0, sel_ff, 2'h0, scan_ff};
         ADDR_SEL: rd_mux = {30'h0, sel_ff};
         ADDR_NPTS: rd_mux = {16'h0, npts_ff};
         ADDR_RATE: rd_mux = rate_ff;
         ADDR_STEP: rd_mux = {16'h0, idx_ff};
         ADDR_MODE: rd_mux = {30'h0, cur.mode};
         ADDR_LEVEL: rd_mux = {16'h0, cur.level};
         ADDR_START: rd_mux = {16'h0, cur.start};
         ADDR_STOP: rd_mux = {16'h0, cur.stop};
         ADDR_OFFS: rd_mux = {16'h0, cur.offset};
         ADDR_OUT: rd_mux = {16'h0, dac_ff[sel_ff]};
         default: rd_mux = '0;
      endcase
   end

   // Command pulses from control writes
   assign cmd_wr = wr_en && avs_address_i == ADDR_CTRL;
   assign cmd_start = cmd_wr & avs_writedata_i[CMD_START_BIT];
   assign cmd_pause = cmd_wr & avs_writedata_i[CMD_PAUSE_BIT];
   assign cmd_reset = cmd_wr & avs_writedata_i[CMD_RESET_BIT];

   // Scan settings; point count and rate change only while idle
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= '0;
         npts_ff <= NPTS_RST;
         rate_ff <= RATE_RST_P;
      end else if (wr_en) begin
         if (avs_address_i == ADDR_CTRL) begin
            ctrl_ff <= avs_writedata_i[2:0];
         end
         if (avs_address_i == ADDR_NPTS && scan_ff == SCAN_IDLE && avs_writedata_i[15:0] != 16'h0) begin
            npts_ff <= avs_writedata_i[15:0];
         end
         if (avs_address_i == ADDR_RATE && scan_ff == SCAN_IDLE && avs_writedata_i != 32'h0) begin
            rate_ff <= avs_writedata_i;
         end
      end
   end

   // Programming selector steps and wraps
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_ff <= '0;
      end else if (cmd_wr & avs_writedata_i[CMD_SEL_BIT]) begin
         sel_ff <= sel_ff + 2'h1;
      end
   end

   // Trigger pin synchroniser and rising-edge detect
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_d_ff <= 1'b0;
      end else begin
         trig_s1_ff <= trig_i;
         trig_s2_ff <= trig_s1_ff;
         trig_d_ff <= trig_s2_ff;
      end
   end
   assign edge_seen = trig_s2_ff & ~trig_d_ff;

   // Internal sample-rate divider runs only while scanning
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rate_cnt_ff <= '0;
      end else if (scan_ff != SCAN_RUN || tick) begin
         rate_cnt_ff <= '0;
      end else begin
         rate_cnt_ff <= rate_cnt_ff + 32'h1;
      end
   end
   assign tick = scan_ff == SCAN_RUN && rate_cnt_ff >= rate_ff - 32'h1;

   // Sample event: trigger edge or internal tick, blocked by pause and reset commands
   assign samp = scan_ff == SCAN_RUN && !cmd_pause && !cmd_reset
                 && (ctrl_ff[CTRL_TRATE_BIT] ? edge_seen : tick);
   assign nxt_idx = idx_ff + 16'h1;
   assign last = nxt_idx == npts_ff;

   // Scan state: reset beats pause beats start
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scan_ff <= SCAN_IDLE;
      end else if (cmd_reset) begin
         scan_ff <= SCAN_IDLE;
      end else if (cmd_pause && scan_ff == SCAN_RUN) begin
         scan_ff <= SCAN_PAUSE;
      end else if (cmd_start && (scan_ff == SCAN_IDLE || scan_ff == SCAN_PAUSE)) begin
         scan_ff <= SCAN_RUN;
      end else if (scan_ff == SCAN_IDLE && ctrl_ff[CTRL_TRIG_BIT] && edge_seen) begin
         scan_ff <= SCAN_RUN;
      end else if (samp && last && !ctrl_ff[CTRL_LOOP_BIT]) begin
         scan_ff <= SCAN_DONE;
      end
   end
   assign scan_run_o = scan_ff == SCAN_RUN;

   // Step index
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_ff <= '0;
      end else if (cmd_reset) begin
         idx_ff <= '0;
      end else if (samp) begin
         idx_ff <= last ? (ctrl_ff[CTRL_LOOP_BIT] ? 16'h0 : npts_ff) : nxt_idx;
      end
   end

   // Channel programming with range checks and output pinning
   assign cur = chan_ff[sel_ff];
   assign wv = signed'(avs_writedata_i[15:0]);
   assign top = OUT_MAX - wv;
   always_comb begin
      nxt_cfg = cur;
      case (avs_address_i)
         ADDR_MODE: begin
            if (avs_writedata_i[1:0] != 2'b11
                && !(scan_ff != SCAN_IDLE && scan_ff != SCAN_DONE && avs_writedata_i[1:0] != MODE_FIXED)) begin
               nxt_cfg.mode = axs_mode_t'(avs_writedata_i[1:0]);
            end
         end
         ADDR_LEVEL: begin
            if (wv >= FIX_MIN && wv <= FIX_MAX) nxt_cfg.level = wv;
         end
         ADDR_START, ADDR_STOP: begin
            if (wv >= LIM_MIN && wv <= LIM_MAX) begin
               if (avs_address_i == ADDR_START) nxt_cfg.start = wv;
               else nxt_cfg.stop = wv;
               if (cur.offset + wv > OUT_MAX) nxt_cfg.offset = top;
            end
         end
         ADDR_OFFS: begin
            if (wv >= OUT_MIN && wv <= OUT_MAX) begin
               nxt_cfg.offset = wv;
               if (cur.start > top) nxt_cfg.start = top < LIM_MIN ? LIM_MIN : top;
               if (cur.stop > top) nxt_cfg.stop = top < LIM_MIN ? LIM_MIN : top;
            end
         end
         default: nxt_cfg = cur;
      endcase
   end

   // Per-channel configuration storage
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            chan_ff[g] <= CHAN_RST;
         end else if (wr_en && sel_ff == 2'(g)) begin
            chan_ff[g] <= nxt_cfg;
         end
      end
   end

   // Sweep operands: descending sweeps run the ascending index backward
   assign cfg = chan_ff[ch_ff];
   assign asc = cfg.stop >= cfg.start;
   assign lo = asc ? cfg.start : cfg.stop;
   assign hi = asc ? cfg.stop : cfg.start;
   assign jdx = asc ? idx_ff : npts_ff - idx_ff;
   assign dlt = cfg.mode == MODE_LIN ? {2'h0, 16'(hi - lo)} : lg_hi - lg_lo;
   assign dvd = dlt * jdx;
   assign div_start = eng_ff == E_SETUP && cfg.mode != MODE_FIXED;

   axs_log2 u_log2 (
      .log_a_i(lo[14:0]),
      .log_b_i(hi[14:0]),
      .log_a_o(lg_lo),
      .log_b_o(lg_hi),
      .exp_i(lg_lo + quot[LW-1:0]),
      .exp_o(exp_v)
   );

   axs_divider u_div (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(div_start),
      .dividend_i(dvd),
      .divisor_i(npts_ff),
      .done_o(div_done),
      .quot_o(quot)
   );

   // Swept value from limits, then signed offset, then clamp
   assign val = cfg.mode == MODE_LIN ? lo + signed'(quot[15:0]) : signed'({1'b0, exp_v});
   assign sum = val + cfg.offset;
   assign clip = sum > OUT_MAX ? OUT_MAX : (sum < OUT_MIN ? OUT_MIN : 16'(sum));

   // Round-robin engine over the channels
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eng_ff <= E_SETUP;
         ch_ff <= '0;
         dac_ff <= '0;
         upd_ff <= '0;
      end else begin
         upd_ff <= '0;
         unique case (eng_ff)
            E_SETUP: begin
               if (cfg.mode == MODE_FIXED) begin
                  dac_ff[ch_ff] <= cfg.level;
                  upd_ff[ch_ff] <= 1'b1;
                  ch_ff <= ch_ff + 2'h1;
               end else begin
                  eng_ff <= E_WAIT;
               end
            end
            E_WAIT: begin
               if (div_done) eng_ff <= E_STORE;
            end
            E_STORE: begin
               dac_ff[ch_ff] <= clip;
               upd_ff[ch_ff] <= 1'b1;
               ch_ff <= ch_ff + 2'h1;
               eng_ff <= E_SETUP;
            end
            default: eng_ff <= E_SETUP;
         endcase
      end
   end
   assign dac_o = dac_ff;
   assign dac_upd_o = upd_ff;

   // Checks
   AST_SEL_WRAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cmd_wr && avs_writedata_i[CMD_SEL_BIT] |=> sel_ff == $past(sel_ff) + 2'h1)
      else $error("selector did not advance");
   AST_PAUSE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      scan_ff == SCAN_PAUSE && !cmd_reset |=> $stable(idx_ff))
      else $error("index moved while paused");
   AST_RESET_CLR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cmd_reset |=> idx_ff == 16'h0 && scan_ff == SCAN_IDLE)
      else $error("scan reset did not clear");
   AST_SINGLE_END: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      samp && last && !ctrl_ff[CTRL_LOOP_BIT] |=> scan_ff == SCAN_DONE && idx_ff == npts_ff
      ##1 (scan_ff == SCAN_DONE || $past(cmd_reset)))
      else $error("single sweep did not stop at end");
   AST_LOOP_WRAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      samp && last && ctrl_ff[CTRL_LOOP_BIT] |=> idx_ff == 16'h0 && scan_ff == SCAN_RUN)
      else $error("loop did not wrap");
   AST_STEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      samp && !last |=> idx_ff == $past(idx_ff) + 16'h1)
      else $error("index did not step");
   AST_MODE_LOCK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_en && avs_address_i == ADDR_MODE && scan_ff == SCAN_RUN && avs_writedata_i[1:0] != MODE_FIXED
      |=> chan_ff[$past(sel_ff)].mode == $past(cur.mode))
      else $error("sweep mode accepted during scan");
   AST_OUT_BOUND: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      eng_ff == E_STORE |=> signed'(dac_ff[$past(ch_ff)]) <= OUT_MAX
      && signed'(dac_ff[$past(ch_ff)]) >= OUT_MIN)
      else $error("output beyond bound");
   AST_TRIG_GO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      scan_ff == SCAN_IDLE && ctrl_ff[CTRL_TRIG_BIT] && edge_seen && !cmd_wr |=> scan_ff == SCAN_RUN)
      else $error("trigger did not start scan");
   AST_LIM_RANGE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_en && avs_address_i == ADDR_START && (wv < LIM_MIN || wv > LIM_MAX)
      |=> $stable(chan_ff[$past(sel_ff)].start))
      else $error("out-of-range limit accepted");
   AST_FIXED_OUT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      eng_ff == E_SETUP && cfg.mode == MODE_FIXED |=> dac_ff[$past(ch_ff)] == $past(cfg.level))
      else $error("fixed level not driven");
endmodule // axs_sweep
